// [inc/tis_pkg.sv]
/*
  Constants and carrier types of the transceiver interrupt status block:
  register offsets, flag positions, reset values and guard timing.
  Assumes a 50 MHz digital clock and a register read port at 6-bit offsets.
*/
package tis_pkg;

  // Register offsets
  localparam logic [5:0] MAIN_EV_OFS = 6'h1a;
  localparam logic [5:0] TIMER_FIELD_EV_OFS = 6'h1b;
  localparam logic [5:0] ERR_WAKEUP_EV_OFS = 6'h1c;
  localparam logic [5:0] TARGET_EV_OFS = 6'h1d;

  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // Main event register fields
  localparam int MAIN_OSC_BIT = 7;
  localparam int MAIN_FIFO_LEVEL_BIT = 6;
  localparam int MAIN_RX_START_BIT = 5;
  localparam int MAIN_RX_END_BIT = 4;
  localparam int MAIN_TX_END_BIT = 3;
  localparam int MAIN_COLLISION_BIT = 2;
  localparam int MAIN_RX_RESTART_BIT = 1;

  // Timer and field event register fields
  localparam int TF_CMD_DONE_BIT = 7;
  localparam int TF_NO_RESP_BIT = 6;
  localparam int TF_GP_TIMER_BIT = 5;
  localparam int TF_FIELD_ON_BIT = 4;
  localparam int TF_FIELD_OFF_BIT = 3;
  localparam int TF_CA_COLLISION_BIT = 2;
  localparam int TF_GUARD_DONE_BIT = 1;
  localparam int TF_BITRATE_BIT = 0;

  // Error and wake-up event register fields
  localparam int EW_CRC_BIT = 7;
  localparam int EW_PARITY_BIT = 6;
  localparam int EW_SOFT_FRAME_BIT = 5;
  localparam int EW_HARD_FRAME_BIT = 4;
  localparam int EW_WAKEUP_TIMEOUT_BIT = 3;
  localparam int EW_AMPLITUDE_BIT = 2;
  localparam int EW_PHASE_BIT = 1;
  localparam int EW_CAPACITANCE_BIT = 0;

  // Target event register fields
  localparam int TG_SLOT_LEVEL_BIT = 6;
  localparam int TG_FIELD_UP_BIT = 5;
  localparam int TG_AUTO_REPLY_BIT = 4;
  localparam int TG_FAST_ACTIVE_BIT = 3;
  localparam int TG_ACTIVE_STAR_BIT = 1;
  localparam int TG_ACTIVE_BIT = 0;

  // FIFO level thresholds in bytes
  localparam logic [9:0] FIFO_RX_LEVEL = 10'h12c;
  localparam logic [9:0] FIFO_TX_LEVEL = 10'h0c8;

  // Guard timing: fixed part plus a step per guard setting count
  localparam int CLK_FREQ_MHZ = 50;
  localparam int GUARD_BASE_US = 75;
  localparam int GUARD_STEP_US = 151;
  localparam int GUARD_BASE_CYC = GUARD_BASE_US * CLK_FREQ_MHZ;
  localparam int GUARD_STEP_CYC_DEF = GUARD_STEP_US * CLK_FREQ_MHZ;
  localparam int GUARD_CNT_W = 22;

  // Level conditions reported by the radio and FIFO engines
  typedef struct packed {
    logic osc_stable;
    logic rx_active;
    logic tx_active;
    logic [9:0] fifo_count;
    logic field_above;
  } tis_levels_t;

  // One-cycle event pulses from the engines
  typedef struct packed {
    logic rx_start;
    logic rx_end;
    logic tx_end;
    logic bit_collision;
    logic rx_restart;
    logic cmd_done;
    logic no_resp_expired;
    logic gp_timer_expired;
    logic ca_collision;
    logic ca_field_switched;
    logic bitrate_found;
    logic crc_error;
    logic parity_error;
    logic soft_frame_flag;
    logic hard_frame_flag;
    logic wakeup_timeout;
    logic amplitude_over;
    logic phase_over;
    logic capacitance_over;
    logic slot_level_flag;
    logic auto_reply_sent;
    logic target_fast_active_flag;
    logic target_active_star_flag;
    logic target_active_flag;
  } tis_pulses_t;

  typedef enum logic [0:0] {
    TIS_GUARD_IDLE = 1'b0,
    TIS_GUARD_WAIT = 1'b1
  } tis_guard_state_t;

endpackage : tis_pkg

// [logic/tis_irq_status.sv]
/*
  Interrupt status logic of a contactless transceiver: four sticky 8-bit
  event registers, read side effects, guard timer for the field-on event
  and the masked interrupt line.
  Assumes all event inputs come from logic on ref_clk, mask values from
  the mask registers, and a host read port that pulses rd_en once per read.
*/
// Behaviour
// - Oscillator stable sets main bit 7
// - Receiving, FIFO above 300 sets bit 6
// - Transmitting, FIFO below 200 sets bit 6
// - Rx start, rx end, tx end, collision flags
// - EMD frame discarded sets main bit 1
// - Command done, no-response, GP timer flags
// - Field rises bit 4, falls bit 3
// - Collision avoidance collision sets bit 2
// - Guard time expiry after field switch-on sets bit 1
// - Initiator bit rate recognised sets bit 0
// - Reading timer or target register clears it
// - Hard framing bit 4, soft bit 5
// - Reading main register clears error register
// - Wake-up timeout flag when option selected
// - Amplitude change over reference sets bit 2
// - Phase change over reference sets bit 1
// - Capacitance change over reference sets bit 0
// - Four free slot numbers sets bit 6
// - Collision-free field on sets target bit 5
// - Automatic anticollision reply sets bit 4
// - Fast automatic reply sent sets bit 3
// - Active* sets bit 1, Active bit 0
// - Mask bit set blocks the interrupt
`timescale 1ns/100ps
`default_nettype none

module tis_irq_status #(
  parameter int GUARD_STEP_CYC = tis_pkg::GUARD_STEP_CYC_DEF,
  parameter bit MAIN_CLEAR_ON_READ = 1'b1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Engine conditions and events
  input wire tis_pkg::tis_levels_t levels,
  input wire tis_pkg::tis_pulses_t pulses,
  input wire logic wakeup_irq_every,
  input wire logic [7:0] nfc_guard_setting,
  // Mask register contents, one bit per flag
  input wire logic [7:0] main_mask,
  input wire logic [7:0] timer_field_mask,
  input wire logic [7:0] error_wakeup_mask,
  input wire logic [7:0] target_mask,
  // Host read port
  input wire logic rd_en,
  input wire logic [5:0] rd_addr,
  output logic [7:0] rd_data,
  output logic rd_valid,
  // Interrupt line, high while an unmasked flag is set
  output logic irq
);

  logic [7:0] main_ev_reg;
  logic [7:0] timer_field_ev_reg;
  logic [7:0] error_wakeup_ev_reg;
  logic [7:0] target_ev_reg;
  logic [7:0] main_set;
  logic [7:0] tf_set;
  logic [7:0] ew_set;
  logic [7:0] tg_set;
  logic osc_prev_reg;
  logic field_prev_reg;
  logic [7:0] rd_data_reg;
  logic rd_valid_reg;
  logic irq_reg;
  logic guard_done;
  tis_pkg::tis_guard_state_t guard_state_reg;
  logic [tis_pkg::GUARD_CNT_W-1:0] guard_cnt_reg;
  logic [31:0] guard_load;
  logic rd_main;
  logic rd_tf;
  logic rd_ew;
  logic rd_tg;

  assign rd_main = rd_en && (rd_addr == tis_pkg::MAIN_EV_OFS);
  assign rd_tf = rd_en && (rd_addr == tis_pkg::TIMER_FIELD_EV_OFS);
  assign rd_ew = rd_en && (rd_addr == tis_pkg::ERR_WAKEUP_EV_OFS);
  assign rd_tg = rd_en && (rd_addr == tis_pkg::TARGET_EV_OFS);

  // Previous levels for edge detection of level conditions
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      osc_prev_reg <= 1'b0;
      field_prev_reg <= 1'b0;
    end
    else
    begin
      osc_prev_reg <= levels.osc_stable;
      field_prev_reg <= levels.field_above;
    end
  end

  // Guard timer: base time plus setting times step
  assign guard_load = 32'(tis_pkg::GUARD_BASE_CYC)
    + 32'(nfc_guard_setting) * 32'(GUARD_STEP_CYC);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      guard_state_reg <= tis_pkg::TIS_GUARD_IDLE;
      guard_cnt_reg <= '0;
    end
    else
    begin
      case (guard_state_reg)
        tis_pkg::TIS_GUARD_IDLE:
        begin
          if (pulses.ca_field_switched)
          begin
            guard_cnt_reg <= guard_load[tis_pkg::GUARD_CNT_W-1:0];
            guard_state_reg <= tis_pkg::TIS_GUARD_WAIT;
          end
        end
        tis_pkg::TIS_GUARD_WAIT:
        begin
          if (guard_cnt_reg <= tis_pkg::GUARD_CNT_W'(1))
          begin
            guard_state_reg <= tis_pkg::TIS_GUARD_IDLE;
          end
          guard_cnt_reg <= guard_cnt_reg - tis_pkg::GUARD_CNT_W'(1);
        end
        default:
        begin
          guard_state_reg <= tis_pkg::TIS_GUARD_IDLE;
        end
      endcase
    end
  end

  // Fires in the last guard cycle, so the flag lands after the full time
  assign guard_done = (guard_state_reg == tis_pkg::TIS_GUARD_WAIT)
    && (guard_cnt_reg <= tis_pkg::GUARD_CNT_W'(1));

  // Set vectors of the four registers
  always_comb
  begin
    main_set = 8'h00;
    tf_set = 8'h00;
    ew_set = 8'h00;
    tg_set = 8'h00;
    main_set[tis_pkg::MAIN_OSC_BIT] = levels.osc_stable && !osc_prev_reg;
    main_set[tis_pkg::MAIN_FIFO_LEVEL_BIT] =
      (levels.rx_active && (levels.fifo_count > tis_pkg::FIFO_RX_LEVEL))
      || (levels.tx_active && (levels.fifo_count < tis_pkg::FIFO_TX_LEVEL));
    main_set[tis_pkg::MAIN_RX_START_BIT] = pulses.rx_start;
    main_set[tis_pkg::MAIN_RX_END_BIT] = pulses.rx_end;
    main_set[tis_pkg::MAIN_TX_END_BIT] = pulses.tx_end;
    main_set[tis_pkg::MAIN_COLLISION_BIT] = pulses.bit_collision;
    main_set[tis_pkg::MAIN_RX_RESTART_BIT] = pulses.rx_restart;
    tf_set[tis_pkg::TF_CMD_DONE_BIT] = pulses.cmd_done;
    tf_set[tis_pkg::TF_NO_RESP_BIT] = pulses.no_resp_expired;
    tf_set[tis_pkg::TF_GP_TIMER_BIT] = pulses.gp_timer_expired;
    tf_set[tis_pkg::TF_FIELD_ON_BIT] = levels.field_above && !field_prev_reg;
    tf_set[tis_pkg::TF_FIELD_OFF_BIT] = !levels.field_above && field_prev_reg;
    tf_set[tis_pkg::TF_CA_COLLISION_BIT] = pulses.ca_collision;
    tf_set[tis_pkg::TF_GUARD_DONE_BIT] = guard_done;
    tf_set[tis_pkg::TF_BITRATE_BIT] = pulses.bitrate_found;
    ew_set[tis_pkg::EW_CRC_BIT] = pulses.crc_error;
    ew_set[tis_pkg::EW_PARITY_BIT] = pulses.parity_error;
    ew_set[tis_pkg::EW_SOFT_FRAME_BIT] = pulses.soft_frame_flag;
    ew_set[tis_pkg::EW_HARD_FRAME_BIT] = pulses.hard_frame_flag;
    ew_set[tis_pkg::EW_WAKEUP_TIMEOUT_BIT] =
      pulses.wakeup_timeout && wakeup_irq_every;
    ew_set[tis_pkg::EW_AMPLITUDE_BIT] = pulses.amplitude_over;
    ew_set[tis_pkg::EW_PHASE_BIT] = pulses.phase_over;
    ew_set[tis_pkg::EW_CAPACITANCE_BIT] = pulses.capacitance_over;
    tg_set[tis_pkg::TG_SLOT_LEVEL_BIT] = pulses.slot_level_flag;
    tg_set[tis_pkg::TG_FIELD_UP_BIT] = pulses.ca_field_switched;
    tg_set[tis_pkg::TG_AUTO_REPLY_BIT] = pulses.auto_reply_sent;
    tg_set[tis_pkg::TG_FAST_ACTIVE_BIT] = pulses.target_fast_active_flag;
    tg_set[tis_pkg::TG_ACTIVE_STAR_BIT] = pulses.target_active_star_flag;
    tg_set[tis_pkg::TG_ACTIVE_BIT] = pulses.target_active_flag;
  end

  // Sticky flags; a set in the clearing cycle wins so no event is lost
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      main_ev_reg <= tis_pkg::FLAGS_RESET;
      timer_field_ev_reg <= tis_pkg::FLAGS_RESET;
      error_wakeup_ev_reg <= tis_pkg::FLAGS_RESET;
      target_ev_reg <= tis_pkg::FLAGS_RESET;
    end
    else
    begin
      main_ev_reg <= ((rd_main && MAIN_CLEAR_ON_READ) ? 8'h00 : main_ev_reg)
        | main_set;
      timer_field_ev_reg <= (rd_tf ? 8'h00 : timer_field_ev_reg) | tf_set;
      error_wakeup_ev_reg <= (rd_main ? 8'h00 : error_wakeup_ev_reg) | ew_set;
      target_ev_reg <= (rd_tg ? 8'h00 : target_ev_reg) | tg_set;
    end
  end

  // Read data shows the value before the side-effect clear
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rd_data_reg <= 8'h00;
      rd_valid_reg <= 1'b0;
    end
    else
    begin
      rd_valid_reg <= rd_en;
      if (rd_main)
      begin
        rd_data_reg <= main_ev_reg;
      end
      else if (rd_tf)
      begin
        rd_data_reg <= timer_field_ev_reg;
      end
      else if (rd_ew)
      begin
        rd_data_reg <= error_wakeup_ev_reg;
      end
      else if (rd_tg)
      begin
        rd_data_reg <= target_ev_reg;
      end
      else if (rd_en)
      begin
        rd_data_reg <= 8'h00;
      end
    end
  end

  // Interrupt line lags the flags by one cycle
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= |(main_ev_reg & ~main_mask)
        || |(timer_field_ev_reg & ~timer_field_mask)
        || |(error_wakeup_ev_reg & ~error_wakeup_mask)
        || |(target_ev_reg & ~target_mask);
    end
  end

  assign rd_data = rd_data_reg;
  assign rd_valid = rd_valid_reg;
  assign irq = irq_reg;

endmodule : tis_irq_status

`default_nettype wire

// [tb/tis_host_model.sv]
/*
  Host model: turns bench read orders into single-cycle reads.
  Assumes the bench raises req for one cycle per read.
*/
`timescale 1ns/100ps
`default_nettype none

module tis_host_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Orders from the bench
  input wire logic req,
  input wire logic [5:0] req_addr,
  // Read port
  output logic rd_en,
  output logic [5:0] rd_addr
);
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rd_en <= 1'b0;
      rd_addr <= 6'h00;
    end
    else
    begin
      rd_en <= req;
      // Idle address toggles, never a trusted stale value
      rd_addr <= req ? req_addr : ~rd_addr;
    end
  end
endmodule : tis_host_model

`default_nettype wire

// [tb/tis_irq_status_asserts.sv]
/*
  Port checker of the interrupt status block.
  Assumes a bind to tis_irq_status, one clock.
*/
`timescale 1ns/100ps
`default_nettype none

module tis_irq_status_asserts (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Inputs
  input wire tis_pkg::tis_levels_t levels,
  input wire tis_pkg::tis_pulses_t pulses,
  input wire logic wakeup_irq_every,
  input wire logic [7:0] main_mask,
  input wire logic [7:0] timer_field_mask,
  input wire logic [7:0] error_wakeup_mask,
  input wire logic [7:0] target_mask,
  input wire logic rd_en,
  input wire logic [5:0] rd_addr,
  // Outputs
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic irq
);
  wire logic rd_main = rd_en && rd_addr == tis_pkg::MAIN_EV_OFS;
  wire logic rd_ew = rd_en && rd_addr == tis_pkg::ERR_WAKEUP_EV_OFS;
  wire logic rd_tg = rd_en && rd_addr == tis_pkg::TARGET_EV_OFS;
  wire logic all_m = &{main_mask, timer_field_mask, error_wakeup_mask, target_mask};

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  chk_read_answer: assert property (rd_en |=> rd_valid)
    else $error("read not answered");
  chk_valid_stray: assert property (!rd_en |=> !rd_valid)
    else $error("answer without read");
  chk_osc_flag: assert property (
    $rose(levels.osc_stable) ##1 !rd_en ##1 rd_main |=> rd_data[7])
    else $error("oscillator flag missing");
  chk_rx_start_flag: assert property (
    pulses.rx_start ##1 !rd_en ##1 rd_main |=> rd_data[5])
    else $error("rx start flag missing");
  chk_wakeup_flag: assert property (
    pulses.wakeup_timeout && wakeup_irq_every ##1 !rd_en ##1 rd_ew |=> rd_data[3])
    else $error("wakeup flag missing");
  chk_error_clear: assert property (
    rd_main && pulses == '0 ##1 !rd_en && pulses == '0 ##1 rd_ew |=> rd_data == 8'h00)
    else $error("error flags not cleared");
  chk_target_clear: assert property (
    rd_tg && pulses == '0 ##1 !rd_en && pulses == '0 ##1 rd_tg |=> rd_data == 8'h00)
    else $error("target flags not cleared");
  chk_mask_quiet: assert property (all_m [*2] |=> !irq)
    else $error("irq while all masked");
  chk_irq_raise: assert property (
    pulses.rx_start && main_mask == 8'h00 ##1 main_mask == 8'h00 |=> irq)
    else $error("irq not raised");
endmodule : tis_irq_status_asserts

`default_nettype wire

// [tb/test_transceiver_irq_status.sv]
/*
  Self-checking bench of the interrupt status block with a host model.
  Assumes the guard step parameter shortened to 4 cycles.
*/
`timescale 1ns/100ps
`default_nettype none

module test_transceiver_irq_status;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  tis_pkg::tis_levels_t levels = '0;
  tis_pkg::tis_pulses_t pulses = '0;
  logic wakeup_irq_every = 1'b0;
  logic [7:0] nfc_guard_setting = 8'h02;
  logic [7:0] main_mask = 8'h00;
  logic [7:0] tf_mask = 8'h00;
  logic [7:0] ew_mask = 8'h00;
  logic [7:0] tg_mask = 8'h00;
  logic req = 1'b0;
  logic [5:0] req_addr = 6'h00;
  logic rd_en;
  logic [5:0] rd_addr;
  logic [7:0] rd_data;
  logic rd_valid;
  logic irq;
  logic [7:0] exp_q [$];
  logic [9:0] fcnt [4] = '{10'h12c, 10'h12d, 10'h0c8, 10'h0c7};
  logic [7:0] r;
  int num_errors = 0;
  int checked = 0;

  always #10 ref_clk = ~ref_clk;

  tis_host_model i_host (.ref_clk, .rst, .req, .req_addr, .rd_en, .rd_addr);

  tis_irq_status #(.GUARD_STEP_CYC(4)) i_dut (.ref_clk, .rst, .levels, .pulses,
    .wakeup_irq_every, .nfc_guard_setting, .main_mask, .timer_field_mask(tf_mask),
    .error_wakeup_mask(ew_mask), .target_mask(tg_mask), .rd_en, .rd_addr, .rd_data,
    .rd_valid, .irq);

  task chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task give_verdict;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict

  task tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  task rd(input logic [5:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    req <= 1'b1;
    req_addr <= a;
    tick(1);
    req <= 1'b0;
    tick(1);
  endtask : rd

  task hit(input tis_pkg::tis_pulses_t p);
    pulses <= p;
    tick(1);
    pulses <= '0;
  endtask : hit

  task irq_is(input logic e);
    @(negedge ref_clk);
    chk("irq", {7'h00, e}, {7'h00, irq});
    tick(1);
  endtask : irq_is

  // Answers come back in order, so one queue pairs them
  always @(negedge ref_clk)
    if (rd_valid === 1'b1)
      chk("rd_data", exp_q.pop_front(), rd_data);

  initial
  begin
    tick(20000);
    num_errors++;
    $display("mismatch watchdog expected done seen timeout");
    give_verdict();
  end

  initial
  begin
    void'($urandom(32'hb1867693));
    tick(3);
    rst <= 1'b0;
    for (int a = 'h1a; a <= 'h1e; a++)
      rd(6'(a), 8'h00);
    levels.osc_stable <= 1'b1;
    hit(24'hf80000);
    rd(tis_pkg::MAIN_EV_OFS, 8'hbe);
    rd(tis_pkg::MAIN_EV_OFS, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      levels.rx_active <= (i < 2);
      levels.tx_active <= (i >= 2);
      levels.fifo_count <= fcnt[i];
      tick(3);
      levels.rx_active <= 1'b0;
      levels.tx_active <= 1'b0;
      levels.fifo_count <= 10'($urandom);
      tick(3);
      rd(tis_pkg::MAIN_EV_OFS, i[0] ? 8'h40 : 8'h00);
    end
    levels.field_above <= 1'b1;
    hit(24'h07a000);
    tick(3);
    rd(tis_pkg::TIMER_FIELD_EV_OFS, 8'hf5);
    rd(tis_pkg::TIMER_FIELD_EV_OFS, 8'h00);
    levels.field_above <= 1'b0;
    tick(3);
    rd(tis_pkg::TIMER_FIELD_EV_OFS, 8'h08);
    hit(24'h004000);
    rd(tis_pkg::TARGET_EV_OFS, 8'h20);
    // Read lands on the very edge that sets the guard flag, two edges of latency
    tick(tis_pkg::GUARD_BASE_CYC + int'(nfc_guard_setting) * 4 - 4);
    rd(tis_pkg::TIMER_FIELD_EV_OFS, 8'h00);
    rd(tis_pkg::TIMER_FIELD_EV_OFS, 8'h02);
    hit(24'h000100);
    rd(tis_pkg::ERR_WAKEUP_EV_OFS, 8'h00);
    wakeup_irq_every <= 1'b1;
    r = 8'($urandom) | 8'h08;
    hit({11'h000, r, 5'h00});
    rd(tis_pkg::ERR_WAKEUP_EV_OFS, r);
    rd(tis_pkg::ERR_WAKEUP_EV_OFS, r);
    rd(tis_pkg::MAIN_EV_OFS, 8'h00);
    rd(tis_pkg::ERR_WAKEUP_EV_OFS, 8'h00);
    hit(24'h00001f);
    rd(tis_pkg::TARGET_EV_OFS, 8'h5b);
    rd(tis_pkg::TARGET_EV_OFS, 8'h00);
    {main_mask, tf_mask, ew_mask, tg_mask} <= '1;
    hit(24'h800000);
    tick(4);
    irq_is(1'b0);
    main_mask <= 8'h00;
    tick(2);
    irq_is(1'b1);
    rd(tis_pkg::MAIN_EV_OFS, 8'h20);
    tick(3);
    irq_is(1'b0);
    tick(5);
    chk("pending reads", 8'h00, 8'(exp_q.size()));
    give_verdict();
  end
endmodule : test_transceiver_irq_status

bind tis_irq_status tis_irq_status_asserts i_chk (.ref_clk, .rst, .levels, .pulses,
  .wakeup_irq_every, .main_mask, .timer_field_mask, .error_wakeup_mask, .target_mask,
  .rd_en, .rd_addr, .rd_data, .rd_valid, .irq);

`default_nettype wire
